// ==== common/dbx_pkg.sv ====
/*
 * constants, field layouts and carrier types of the debug bus-grant
 * and instruction/memory write register block.
 * assumes a byte-wide debug write stream already decoded from the
 * serial debug port, and a cpu core that owns the program counter.
 */
// Functional notes
// RQ1 - bus grant control is write-only at 17h and resets to zero; bits 5:0 reserved.
// RQ2 - with grant enable clear, bus requests are ignored and never granted.
// RQ3 - with grant enable set, requests are granted once the debug operation ends.
// RQ4 - writing one to force grant asserts the bus grant output.
// RQ5 - writing zero to force grant deasserts the grant, buses return to debug.
// RQ6 - writing store register zero makes the cpu execute exactly one instruction.
// RQ7 - cpu fetches store byte zero first, then bytes one to four as needed.
// RQ8 - the master loads only the bytes the instruction needs.
// RQ9 - the master never runs six-byte instructions through the store registers.
// RQ10 - store bytes four..zero sit at ascending addresses; byte zero last starts execution.
// RQ11 - memory port bytes go to {upper base, pc[15:0]} or pc[23:0] in wide mode.
// RQ12 - the program counter increments after every byte stored through the port.
// RQ13 - memory port accesses do not advance the debug register address.
// RQ14 - the master addresses the memory port once, then streams any number of bytes.
// RQ15 - the master writes bus grant control only while the cpu is halted in debug.
`default_nettype none

package dbx_pkg;

    // ****************************************************************
    // register addresses in the debug write space
    // ****************************************************************
    localparam logic [7:0] DBX_ADDR_BUS_CTL = 8'h17;
    localparam logic [7:0] DBX_ADDR_IS4 = 8'h21;
    localparam logic [7:0] DBX_ADDR_IS3 = 8'h22;
    localparam logic [7:0] DBX_ADDR_IS2 = 8'h23;
    localparam logic [7:0] DBX_ADDR_IS1 = 8'h24;
    localparam logic [7:0] DBX_ADDR_IS0 = 8'h25;
    localparam logic [7:0] DBX_ADDR_MEM_WR = 8'h30;

    // ****************************************************************
    // bus grant control fields and reset value
    // ****************************************************************
    localparam int DBX_BIT_GRANT_EN = 7;
    localparam int DBX_BIT_GRANT_FORCE = 6;
    localparam logic [7:0] DBX_BUS_CTL_RESET = 8'h00;
    localparam logic [7:0] DBX_BUS_CTL_MASK = 8'hc0;

    // ****************************************************************
    // counts of synchroniser stages and buffer entries
    // ****************************************************************
    localparam int DBX_SYNC_STAGES = 3;
    localparam int DBX_BUF_DEPTH = 2;

    // ****************************************************************
    // carrier types
    // ****************************************************************
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } dbx_wr_type;

    // byte0 is the opcode the cpu fetches first
    typedef struct packed {
        logic [7:0] byte4;
        logic [7:0] byte3;
        logic [7:0] byte2;
        logic [7:0] byte1;
        logic [7:0] byte0;
    } dbx_instr_type;

    typedef enum logic [2:0] {
        DBX_ST_IDLE,
        DBX_ST_MEM,
        DBX_ST_SETTLE,
        DBX_ST_EXEC_REQ,
        DBX_ST_EXEC_RUN
    } dbx_state_type;

endpackage : dbx_pkg

`default_nettype wire

// ==== verilog/dbx_pair_buffer.sv ====
/*
 * small valid/ready buffer holding decoded debug writes.
 * assumes one clock and the released active-low reset copy.
 */
`timescale 1ns/1ns
`default_nettype none

module dbx_pair_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    input wire logic i_clk, // core clock
    input wire logic i_rst_n, // released reset, active low
    input wire logic i_in_valid, // fill side word offered
    output logic o_in_ready, // fill side has room
    input wire logic [WIDTH-1:0] i_in_data, // fill side word
    output logic o_out_valid, // drain side word present
    input wire logic i_out_ready, // drain side takes the word
    output logic [WIDTH-1:0] o_out_data // oldest word
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] slot_q [0:DEPTH-1];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] count_q;
    logic push;
    logic pop;

    // ****************************************************************
    // handshakes
    // ****************************************************************
    assign o_in_ready = (count_q != DEPTH[PW:0]);
    assign o_out_valid = (count_q != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = slot_q[rd_q];

    // storage never resets, occupancy guards it
    always_ff @(posedge i_clk) begin
        if (push) begin
            slot_q[wr_q] <= i_in_data;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            count_q <= count_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        end
    end

endmodule : dbx_pair_buffer

`default_nettype wire

// ==== verilog/dbx_debug_write_regs.sv ====
/*
 * write-only debug registers: bus grant control, instruction store
 * with execute, and the streaming memory write port.
 * assumes a debug write link sampled on its own clock pin, a cpu that
 * owns pc/upper base/wide mode and pulses done after one instruction.
 */
`timescale 1ns/1ns
`default_nettype none

module dbx_debug_write_regs (
    input wire logic i_clk, // core clock, 250 mhz
    input wire logic i_resetn, // asynchronous reset, active low
    input wire logic i_link_clk, // debug link clock pin
    input wire logic i_link_addr_valid, // link carries a register address
    input wire logic i_link_data_valid, // link carries a data byte
    input wire logic [7:0] i_link_byte, // link address or data byte
    output logic o_link_ready, // buffer has room for the next byte
    input wire logic i_ext_bus_request, // external bus request pin
    output logic o_ext_bus_grant, // external bus grant pin
    input wire logic [23:0] i_cpu_pc, // cpu program counter
    input wire logic [7:0] i_upper_address_base, // cpu upper address base
    input wire logic i_wide_address_mode, // cpu wide-address mode
    output logic o_pc_increment, // one-cycle pulse: cpu bumps pc
    output logic o_mem_wr_valid, // memory write request
    input wire logic i_mem_wr_ready, // memory accepts the write
    output logic [23:0] o_mem_addr, // memory write address
    output logic [7:0] o_mem_data, // memory write data
    output logic o_exec_valid, // instruction offered to cpu
    input wire logic i_exec_ready, // cpu leaves break and takes it
    input wire logic i_exec_done, // one-cycle pulse: instruction ended
    output dbx_pkg::dbx_instr_type o_exec_instr // instruction bytes
);
    import dbx_pkg::*;

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic [1:0] rst_sync_q;
    logic rst_n;

    // two flops so every block leaves reset on the same edge
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [DBX_SYNC_STAGES-1:0] clk_s_q;
    logic [DBX_SYNC_STAGES-1:0] req_s_q;
    logic [DBX_SYNC_STAGES-1:0] av_s_q;
    logic [DBX_SYNC_STAGES-1:0] dv_s_q;
    logic [7:0] byte_s_q [0:DBX_SYNC_STAGES-1];
    logic link_lvl_q;
    logic req_lvl_q;
    logic link_rise;

    // only stage two and three are compared; stage one feeds stage two alone
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_s_q <= '0;
            req_s_q <= '0;
            av_s_q <= '0;
            dv_s_q <= '0;
            for (int i = 0; i < DBX_SYNC_STAGES; i++) begin
                byte_s_q[i] <= 8'h00;
            end
        end else begin
            clk_s_q <= {clk_s_q[1:0], i_link_clk};
            req_s_q <= {req_s_q[1:0], i_ext_bus_request};
            av_s_q <= {av_s_q[1:0], i_link_addr_valid};
            dv_s_q <= {dv_s_q[1:0], i_link_data_valid};
            byte_s_q[0] <= i_link_byte;
            for (int i = 1; i < DBX_SYNC_STAGES; i++) begin
                byte_s_q[i] <= byte_s_q[i-1];
            end
        end
    end

    // filtered levels change only once stage two and three agree
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_lvl_q <= 1'b0;
            req_lvl_q <= 1'b0;
        end else begin
            if (clk_s_q[1] == clk_s_q[2]) begin
                link_lvl_q <= clk_s_q[2];
            end
            if (req_s_q[1] == req_s_q[2]) begin
                req_lvl_q <= req_s_q[2];
            end
        end
    end
    assign link_rise = (clk_s_q[1] == clk_s_q[2]) && clk_s_q[2] && !link_lvl_q;

    // ****************************************************************
    // link address tracking
    // ****************************************************************
    logic [7:0] reg_addr_q;
    logic data_take;
    dbx_wr_type push_word;

    assign data_take = link_rise && !av_s_q[2] && dv_s_q[2];
    assign push_word = '{addr: reg_addr_q, data: byte_s_q[2]};

    // a byte the buffer cannot hold is dropped; the master must watch ready
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_addr_q <= 8'h00;
        end else if (link_rise && av_s_q[2]) begin
            reg_addr_q <= byte_s_q[2];
        end else if (data_take && reg_addr_q != DBX_ADDR_MEM_WR) begin // [RQ13]
            reg_addr_q <= reg_addr_q + 8'h01; // [RQ10]
        end
    end

    // ****************************************************************
    // write buffer between link and executor
    // ****************************************************************
    logic buf_valid;
    logic buf_take;
    dbx_wr_type buf_word;
    dbx_state_type state_q;

    dbx_pair_buffer #(
        .WIDTH($bits(dbx_wr_type)),
        .DEPTH(DBX_BUF_DEPTH)
    ) u_buffer (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_in_valid(data_take),
        .o_in_ready(o_link_ready),
        .i_in_data(push_word),
        .o_out_valid(buf_valid),
        .i_out_ready(state_q == DBX_ST_IDLE),
        .o_out_data(buf_word)
    );
    assign buf_take = buf_valid && (state_q == DBX_ST_IDLE);

    // ****************************************************************
    // bus grant control
    // ****************************************************************
    logic [7:0] bus_ctl_q;
    logic grant_q;
    logic grant_en;
    logic grant_force;

    // reserved bits are never stored, so they stay zero
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_ctl_q <= DBX_BUS_CTL_RESET; // [RQ1]
        end else if (buf_take && buf_word.addr == DBX_ADDR_BUS_CTL) begin
            bus_ctl_q <= buf_word.data & DBX_BUS_CTL_MASK; // [RQ1]
        end
    end
    assign grant_en = bus_ctl_q[DBX_BIT_GRANT_EN];
    assign grant_force = bus_ctl_q[DBX_BIT_GRANT_FORCE];

    // a granted request holds the bus; a new request grant waits for an idle executor, a forced grant does not
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            grant_q <= 1'b0;
        end else begin
            grant_q <= grant_force // [RQ4] [RQ5]
                || (grant_en && req_lvl_q // [RQ2]
                    && (grant_q || state_q == DBX_ST_IDLE)); // [RQ3]
        end
    end
    assign o_ext_bus_grant = grant_q;

    // ****************************************************************
    // instruction store and memory write executor
    // ****************************************************************
    dbx_instr_type instr_q;
    logic [23:0] mem_addr_q;
    logic [7:0] mem_data_q;
    logic pc_inc_q;
    logic mem_fire;

    // memory writes hold off while the bus belongs to an outside master
    assign mem_fire = (state_q == DBX_ST_MEM) && !grant_q && i_mem_wr_ready;

    // store bytes; byte zero lands last and launches execution
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_q <= '0;
        end else if (buf_take) begin
            if (buf_word.addr == DBX_ADDR_IS4) begin
                instr_q.byte4 <= buf_word.data;
            end else if (buf_word.addr == DBX_ADDR_IS3) begin
                instr_q.byte3 <= buf_word.data;
            end else if (buf_word.addr == DBX_ADDR_IS2) begin
                instr_q.byte2 <= buf_word.data;
            end else if (buf_word.addr == DBX_ADDR_IS1) begin
                instr_q.byte1 <= buf_word.data;
            end else if (buf_word.addr == DBX_ADDR_IS0) begin
                instr_q.byte0 <= buf_word.data; // [RQ7]
            end
        end
    end

    // address is frozen when the byte is taken, so a pc bump cannot race it
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_addr_q <= 24'h000000;
            mem_data_q <= 8'h00;
        end else if (buf_take && buf_word.addr == DBX_ADDR_MEM_WR) begin
            mem_data_q <= buf_word.data;
            mem_addr_q <= i_wide_address_mode ? i_cpu_pc // [RQ11]
                : {i_upper_address_base, i_cpu_pc[15:0]}; // [RQ11]
        end
    end

    // one pc step per stored byte
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_inc_q <= 1'b0;
        end else begin
            pc_inc_q <= mem_fire; // [RQ12]
        end
    end

    // settle lets the cpu show the new pc before the next byte is taken
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= DBX_ST_IDLE;
        end else begin
            case (state_q)
                DBX_ST_IDLE: begin
                    if (buf_take && buf_word.addr == DBX_ADDR_MEM_WR) begin
                        state_q <= DBX_ST_MEM;
                    end else if (buf_take && buf_word.addr == DBX_ADDR_IS0) begin
                        state_q <= DBX_ST_EXEC_REQ; // [RQ6]
                    end
                end
                DBX_ST_MEM: begin
                    if (mem_fire) begin
                        state_q <= DBX_ST_SETTLE;
                    end
                end
                DBX_ST_SETTLE: begin
                    state_q <= DBX_ST_IDLE;
                end
                DBX_ST_EXEC_REQ: begin
                    if (i_exec_ready) begin
                        state_q <= DBX_ST_EXEC_RUN;
                    end
                end
                DBX_ST_EXEC_RUN: begin
                    if (i_exec_done) begin
                        state_q <= DBX_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= DBX_ST_IDLE;
                end
            endcase
        end
    end

    // outputs
    assign o_mem_wr_valid = (state_q == DBX_ST_MEM) && !grant_q;
    assign o_mem_addr = mem_addr_q;
    assign o_mem_data = mem_data_q;
    assign o_pc_increment = pc_inc_q;
    assign o_exec_valid = (state_q == DBX_ST_EXEC_REQ); // [RQ6]
    assign o_exec_instr = instr_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    a_ctl_reset_zero: assert property ($rose(rst_sync_q[1]) |-> bus_ctl_q == 8'h00) // [RQ1]
        else $error("bus grant control not zero after reset");
    a_ctl_reserved: assert property (bus_ctl_q[5:0] == 6'h00) // [RQ1]
        else $error("reserved control bits stored");
    a_grant_disabled: assert property (!grant_en && !grant_force |=> !o_ext_bus_grant) // [RQ2]
        else $error("grant asserted while disabled");
    a_grant_waits_op: assert property ( // [RQ3]
        grant_en && !grant_force && !grant_q && state_q != DBX_ST_IDLE |=> !o_ext_bus_grant
    ) else $error("grant given during a debug operation");
    a_grant_after_op: assert property ( // [RQ3]
        grant_en && req_lvl_q && state_q == DBX_ST_IDLE |=> o_ext_bus_grant
    ) else $error("enabled request not granted when idle");
    a_force_grant: assert property (grant_force |=> o_ext_bus_grant) // [RQ4]
        else $error("forced grant not asserted");
    // the grant flop still shows the old force value in the cycle the field falls
    a_force_release: assert property ($fell(grant_force) && !grant_en |=> !o_ext_bus_grant) // [RQ5]
        else $error("grant held after force cleared");
    a_exec_launch: assert property ( // [RQ6]
        buf_take && buf_word.addr == DBX_ADDR_IS0
        |=> o_exec_valid && o_exec_instr.byte0 == $past(buf_word.data)
    ) else $error("store byte zero did not launch execution");
    a_exec_single: assert property (o_exec_valid && i_exec_ready |=> !o_exec_valid) // [RQ6]
        else $error("instruction offered twice");
    a_mem_compat_addr: assert property ( // [RQ11]
        buf_take && buf_word.addr == DBX_ADDR_MEM_WR && !i_wide_address_mode
        |=> o_mem_addr == {$past(i_upper_address_base), $past(i_cpu_pc[15:0])}
    ) else $error("compatibility address wrong");
    a_mem_wide_addr: assert property ( // [RQ11]
        buf_take && buf_word.addr == DBX_ADDR_MEM_WR && i_wide_address_mode
        |=> o_mem_addr == $past(i_cpu_pc)
    ) else $error("wide address wrong");
    a_pc_step: assert property ( // [RQ12]
        o_mem_wr_valid && i_mem_wr_ready |=> o_pc_increment ##1 !o_pc_increment
    ) else $error("pc not stepped once per byte");
    a_port_addr_hold: assert property ( // [RQ13]
        data_take && reg_addr_q == DBX_ADDR_MEM_WR |=> reg_addr_q == DBX_ADDR_MEM_WR
    ) else $error("memory port address advanced");
    a_store_addr_step: assert property ( // [RQ10]
        data_take && reg_addr_q == DBX_ADDR_IS4 |=> reg_addr_q == DBX_ADDR_IS3
    ) else $error("store address did not advance");

    c_exec_done: cover property (o_exec_valid ##1 (state_q == DBX_ST_EXEC_RUN) ##[1:50] i_exec_done);
    c_mem_write: cover property (o_mem_wr_valid && i_mem_wr_ready);
    c_forced_grant: cover property ($rose(o_ext_bus_grant) && grant_force);
    c_buffer_full: cover property (!o_link_ready);

endmodule : dbx_debug_write_regs

`default_nettype wire

// ==== tb/dbx_link_master.sv ====
/*
 * model of the external debug master on the sampled link: one frame
 * per byte, address or data. assumes the core clock paces it.
 */
`timescale 1ns/1ns
`default_nettype none

module dbx_link_master (
    input wire logic i_clk, // core clock, paces the link
    input wire logic i_ready, // device buffer has room
    output logic o_link_clk, // link clock, still low between frames
    output logic o_addr_valid, // byte is a register address
    output logic o_data_valid, // byte is data
    output logic [7:0] o_byte, // address or data byte
    output int o_stalls // frames held back by a full buffer
);
    // ****************************************************************
    // framing
    // ****************************************************************
    initial begin
        o_link_clk = 1'b0;
        o_addr_valid = 1'b0;
        o_data_valid = 1'b0;
        o_byte = 8'h00;
        o_stalls = 0;
    end

    // one 80 ns period per byte; data sent into a full buffer is lost, so wait
    task automatic put_byte(input logic is_addr, input logic [7:0] b);
        int k;
        k = 0;
        while (i_ready !== 1'b1 && k < 4000) begin
            @(negedge i_clk);
            k++;
        end
        if (k > 0) o_stalls++;
        o_addr_valid = is_addr;
        o_data_valid = ~is_addr;
        o_byte = b;
        repeat (9) @(negedge i_clk);
        o_link_clk = 1'b1;
        repeat (10) @(negedge i_clk);
        o_link_clk = 1'b0;
        // released lines flip so a stale byte never passes for a fresh one
        o_addr_valid = 1'b0;
        o_data_valid = 1'b0;
        o_byte = ~b;
        // one edge apart, so a following frame never drives a line twice in a step
        @(negedge i_clk);
    endtask : put_byte
endmodule : dbx_link_master

`default_nettype wire

// ==== tb/dbx_debug_write_regs_bench.sv ====
/*
 * self-checking bench: grant control, instruction store and memory
 * port stream. assumes the link master model and a small cpu stand-in.
 */
`timescale 1ns/1ns
`default_nettype none

module dbx_debug_write_regs_bench;
    import dbx_pkg::*;
    logic clk, resetn, link_clk, addr_v, data_v, link_ready, bus_req, grant;
    logic pc_inc, mem_valid, mem_stall, exec_valid, cpu_hold, wide;
    logic mem_ready = 1'b0, exec_ready = 1'b0, exec_done = 1'b0;
    logic [7:0] link_byte, mem_data, base;
    logic [23:0] pc, mem_addr, full;
    dbx_instr_type instr, got_instr;
    logic [31:0] mem_q[$];
    int err_total, n_checks, stalls, exec_cnt, busy, n;

    dbx_debug_write_regs i_dut (
        .i_clk(clk), .i_resetn(resetn), .i_link_clk(link_clk),
        .i_link_addr_valid(addr_v), .i_link_data_valid(data_v), .i_link_byte(link_byte),
        .o_link_ready(link_ready), .i_ext_bus_request(bus_req), .o_ext_bus_grant(grant),
        .i_cpu_pc(pc), .i_upper_address_base(base), .i_wide_address_mode(wide),
        .o_pc_increment(pc_inc), .o_mem_wr_valid(mem_valid), .i_mem_wr_ready(mem_ready),
        .o_mem_addr(mem_addr), .o_mem_data(mem_data), .o_exec_valid(exec_valid),
        .i_exec_ready(exec_ready), .i_exec_done(exec_done), .o_exec_instr(instr)
    );

    dbx_link_master i_link (
        .i_clk(clk), .i_ready(link_ready), .o_link_clk(link_clk), .o_addr_valid(addr_v),
        .o_data_valid(data_v), .o_byte(link_byte), .o_stalls(stalls)
    );

    // ****************************************************************
    // clock, cpu stand-in and memory monitor
    // ****************************************************************
    initial clk = 1'b0;
    always #2 clk = ~clk;

    // cpu takes an offered instruction unless held, and ends it 4 cycles later
    always @(negedge clk) begin
        exec_ready <= exec_valid && !cpu_hold && !exec_ready && busy == 0;
        exec_done <= (busy == 1);
        mem_ready <= !mem_stall;
        if (exec_ready) begin
            exec_cnt <= exec_cnt + 1;
            got_instr <= instr;
            busy <= 3;
        end else if (busy > 0) begin
            busy <= busy - 1;
        end
    end

    // the cpu shows the bumped pc before the executor looks again
    always @(posedge clk) begin
        if (mem_valid === 1'b1 && mem_ready === 1'b1) mem_q.push_back({mem_addr, mem_data});
        if (pc_inc === 1'b1) pc <= pc + 24'h000001;
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic settle(input int c);
        repeat (c) @(negedge clk);
    endtask : settle

    task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t ns: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check

    // address then one data byte; the slack covers the pin synchronisers
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        i_link.put_byte(1'b1, a);
        i_link.put_byte(1'b0, d);
        settle(20);
    endtask : wr_reg

    task automatic end_sim;
        if (err_total == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    // tests need some 1,000 cycles; 50,000 leaves room for slow stalls
    initial begin
        #200000;
        err_total++;
        end_sim();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        resetn = 1'b0;
        bus_req = 1'b0;
        mem_stall = 1'b0;
        cpu_hold = 1'b0;
        wide = 1'b0;
        base = 8'hab;
        pc = 24'h12fffe;
        settle(10);
        resetn = 1'b1;
        bus_req = 1'b1;
        settle(20);
        check(grant, 1'b0, "grant after reset");
        wr_reg(DBX_ADDR_BUS_CTL, 8'h3f);
        check(grant, 1'b0, "reserved bits");
        bus_req = 1'b0;
        wr_reg(DBX_ADDR_BUS_CTL, 8'h40);
        check(grant, 1'b1, "forced grant");
        wr_reg(DBX_ADDR_BUS_CTL, 8'h00);
        check(grant, 1'b0, "force released");
        wr_reg(DBX_ADDR_BUS_CTL, 8'h80);
        check(grant, 1'b0, "enabled, no request");
        bus_req = 1'b1;
        settle(20);
        check(grant, 1'b1, "enabled request");
        bus_req = 1'b0;
        // request arrives while a one-byte instruction is still pending
        cpu_hold = 1'b1;
        wr_reg(DBX_ADDR_IS0, 8'h76);
        bus_req = 1'b1;
        settle(20);
        check(exec_valid, 1'b1, "exec offered");
        check(grant, 1'b0, "grant during exec");
        cpu_hold = 1'b0;
        settle(30);
        check(grant, 1'b1, "grant after exec");
        check(got_instr.byte0, 8'h76, "one byte opcode");
        bus_req = 1'b0;
        wr_reg(DBX_ADDR_BUS_CTL, 8'h00);
        // five bytes in one stream, execution only on the last
        i_link.put_byte(1'b1, DBX_ADDR_IS4);
        for (int i = 0; i < 5; i++) i_link.put_byte(1'b0, 8'h15 + 8'h11 * i[7:0]);
        settle(30);
        check(got_instr, 40'h1526374859, "five byte instr");
        check(exec_cnt, 2, "one exec per stream");
        i_link.put_byte(1'b1, DBX_ADDR_IS1);
        i_link.put_byte(1'b0, 8'hdd);
        i_link.put_byte(1'b0, 8'hed);
        settle(30);
        check(got_instr[15:0], 16'hdded, "two byte instr");
        check(exec_cnt, 3, "exec count");
        // memory stream across a 64k boundary with the memory stalled
        mem_stall = 1'b1;
        i_link.put_byte(1'b1, DBX_ADDR_MEM_WR);
        fork
            for (int i = 0; i < 4; i++) i_link.put_byte(1'b0, 8'hc0 + i[7:0]);
            begin
                n = 0;
                while (link_ready !== 1'b0 && n < 2000) begin
                    settle(1);
                    n++;
                end
                settle(40);
                mem_stall = 1'b0;
            end
        join
        settle(30);
        check(stalls != 0, 1'b1, "buffer refused");
        wide = 1'b1;
        i_link.put_byte(1'b0, 8'hc4);
        i_link.put_byte(1'b0, 8'hc5);
        settle(30);
        check(mem_q.size(), 6, "memory write count");
        for (int i = 0; i < 6; i++) begin
            full = 24'h12fffe + i[23:0];
            if (i < 4) full = {8'hab, full[15:0]};
            check(mem_q[i], {full, 8'hc0 + i[7:0]}, "memory write");
        end
        check(pc, 24'h130004, "final pc");
        end_sim();
    end
endmodule : dbx_debug_write_regs_bench

`default_nettype wire
